// ===== hw/element_memory_output_stage.sv
// Output stage driving the element memory, with AXI4-Lite control registers
//
// Behaviour
// [R1] Initiate pulse: one clock in read cycles, 50 ns in write cycles.
// [R2] Initiate pulse starts near 30 ns (read) or 70 ns (write).
// [R3] Write data to memory becomes valid near 70 ns into the write cycle.
// [R4] Memory write data comes from holding latches loaded at cycle start.
// [R5] Inner-word enable raised when the inner half is to be stored.
// [R6] Outer-word enable raised when the outer half is to be stored.
// [R7] Inner enable covers bits 8 to 39 only; memory writes them only then.
// [R8] Outer enable covers bits 0-7 and 40-63 only; memory writes them only then.
// [R9] Asserted write enables stand from about 60 ns to 210 ns.
// [R10] Address bits 05 to 15 go to memory for reads and writes.
// [R11] Protection check examines the four low address bits 05 to 08.
// [R12] Outputs toward memory are active high; internal flag is active low.
// [R13] Strobe near 40 ns sets error flag on violation, else write-enable flop.
// [R14] Transfer cycles never set the write-enable flop, so no enables.
// [R15] Full write raises both enables; half write only the selected one.
// [R16] All in-cycle times come from a clock-counting sequencer started per cycle.
`timescale 1ns/100ps

module element_memory_output_stage
  import element_memory_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Processing element side
  input  wire logic                  start_write,
  input  wire logic                  start_read,
  input  wire logic                  start_transfer,
  input  wire logic [10:0]           element_address_bits,
  input  wire logic [63:0]           element_write_data,
  input  wire logic                  write_inner_sel,
  input  wire logic                  write_outer_sel,
  output logic                       cycle_busy,
  // Element memory side
  output logic [10:0]                memory_address_outputs,
  output logic [63:0]                memory_write_data_bits,
  output logic                       memory_initiate_pulse,
  output logic                       inner_word_write_enable,
  output logic                       outer_word_write_enable
);

  typedef struct packed {
    // Timing sequencer
    seq_state_t            state;
    cycle_kind_t           kind;
    logic [7:0]            count;
    // Cycle latches
    logic [63:0]           data_latch;
    logic                  inner_sel;
    logic                  outer_sel;
    logic                  violation;
    logic                  we_ff_n;
    // Software visible
    logic                  check_en;
    logic [15:0]           prot_mask;
    logic                  prot_err;
    logic [10:0]           err_addr;
    // Memory side outputs, plus the busy flag
    logic [10:0]           mem_addr;
    logic [63:0]           mem_wdata;
    logic                  init;
    logic                  inner_we;
    logic                  outer_we;
    logic                  busy;
    // Bus slave
    logic                  awready;
    logic                  wready;
    logic                  aw_have;
    logic                  w_have;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } state_t;

  state_t q;
  state_t d;

  logic [7:0] wr_word;
  logic [7:0] rd_word;
  logic       run;
  logic       is_write;
  logic       we_window;
  logic       init_rd;
  logic       init_wr;
  logic       prot_strobe;

  always_comb
  begin
    d         = q;
    wr_word   = {q.awaddr[AXI_ADDR_W-1:2], 2'b00};
    rd_word   = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
    run       = 1'b0;
    is_write  = 1'b0;
    we_window = 1'b0;
    init_rd   = 1'b0;
    init_wr   = 1'b0;
    prot_strobe = 1'b0;

    // Write address and data channels, taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.awaddr  = s_axi_awaddr;
      d.aw_have = 1'b1;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
      d.w_have = 1'b1;
      d.wready = 1'b0;
    end

    // Register write once both halves are held
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (wr_word == OFS_CTRL)
      begin
        if (q.wstrb[0])
        begin
          d.check_en = q.wdata[CTRL_CHECK_EN_BIT];
        end
      end
      else if (wr_word == OFS_MASK)
      begin
        if (q.wstrb[0])
        begin
          d.prot_mask[7:0] = q.wdata[7:0];
        end
        if (q.wstrb[1])
        begin
          d.prot_mask[15:8] = q.wdata[15:8];
        end
      end
      else if (wr_word == OFS_STATUS)
      begin
        // Write one to clear; a same-cycle set below wins
        if (q.wstrb[0] && q.wdata[STAT_PERR_BIT])
        begin
          d.prot_err = 1'b0;
        end
      end
      else if (wr_word == OFS_ERRADDR)
      begin
        d.bresp = RESP_OKAY;
      end
      else
      begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // Read channel, answer one cycle after the address is taken
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      d.rdata   = 32'h0000_0000;
      if (rd_word == OFS_CTRL)
      begin
        d.rdata[CTRL_CHECK_EN_BIT] = q.check_en;
      end
      else if (rd_word == OFS_MASK)
      begin
        d.rdata[15:0] = q.prot_mask;
      end
      else if (rd_word == OFS_STATUS)
      begin
        d.rdata[STAT_BUSY_BIT] = q.busy;
        d.rdata[STAT_PERR_BIT] = q.prot_err;
      end
      else if (rd_word == OFS_ERRADDR)
      begin
        d.rdata[10:0] = q.err_addr;
      end
      else
      begin
        d.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // Timing sequencer
    case (q.state)
      SEQ_IDLE:
      begin
        if (start_write || start_read || start_transfer)
        begin
          d.state      = SEQ_RUN; // R16
          d.count      = 8'h00;
          d.busy       = 1'b1;
          d.we_ff_n    = 1'b1;
          d.data_latch = element_write_data; // R4
          d.inner_sel  = write_inner_sel;
          d.outer_sel  = write_outer_sel;
          d.violation  = q.check_en && q.prot_mask[element_address_bits[3:0]]; // R11
          if (start_write)
          begin
            d.kind     = KIND_WRITE;
            d.mem_addr = element_address_bits; // R10
          end
          else if (start_read)
          begin
            d.kind     = KIND_READ;
            d.mem_addr = element_address_bits; // R10
          end
          else
          begin
            d.kind = KIND_XFER;
          end
        end
      end
      SEQ_RUN:
      begin
        d.count = q.count + 8'h01; // R16
        // Transfer cycles skip the strobe; the address latch is stale then
        prot_strobe = (d.count == PROT_CYC) && (q.kind != KIND_XFER); // R13 R14
        if (prot_strobe)
        begin
          if (q.violation)
          begin
            d.prot_err = 1'b1; // R13
            d.err_addr = q.mem_addr;
          end
          else
          begin
            d.we_ff_n = 1'b0; // R13 R12
          end
        end
        if (d.count == CYCLE_END)
        begin
          d.state   = SEQ_IDLE;
          d.busy    = 1'b0;
          d.we_ff_n = 1'b1;
        end
      end
      default:
      begin
        d.state = SEQ_IDLE;
        d.busy  = 1'b0;
      end
    endcase

    // Memory side outputs, registered so they align with the count
    run      = (d.state == SEQ_RUN);
    is_write = run && (d.kind == KIND_WRITE);
    // Read pulse is one clock; write pulse spans WR_INIT_LEN clocks
    init_rd  = run && (d.kind == KIND_READ) && (d.count == RD_INIT_CYC); // R1 R2
    init_wr  = is_write && (d.count >= WR_INIT_CYC)
               && (d.count < WR_INIT_CYC + WR_INIT_LEN); // R1 R2
    d.init   = init_rd || init_wr; // R12
    // Data reaches the memory bus together with the write pulse
    if (is_write && (d.count == WDATA_CYC))
    begin
      d.mem_wdata = q.data_latch; // R3 R4
    end
    // Enables need the armed write flop, so violations never store
    we_window  = is_write && !d.we_ff_n
                 && (d.count >= WE_START_CYC) && (d.count < WE_END_CYC); // R9 R14
    d.inner_we = we_window && d.inner_sel; // R5 R7 R15
    d.outer_we = we_window && d.outer_sel; // R6 R8 R15
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q            <= '0;
      q.state      <= SEQ_IDLE;
      q.kind       <= KIND_READ;
      q.we_ff_n    <= 1'b1;
      q.check_en   <= CHECK_EN_RST;
      q.prot_mask  <= PROT_MASK_RST;
      // Ready outputs start high so the first request is taken at once
      q.awready    <= 1'b1;
      q.wready     <= 1'b1;
      q.arready    <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign s_axi_awready           = q.awready;
  assign s_axi_wready            = q.wready;
  assign s_axi_bresp             = q.bresp;
  assign s_axi_bvalid            = q.bvalid;
  assign s_axi_arready           = q.arready;
  assign s_axi_rdata             = q.rdata;
  assign s_axi_rresp             = q.rresp;
  assign s_axi_rvalid            = q.rvalid;
  assign cycle_busy              = q.busy;
  assign memory_address_outputs  = q.mem_addr;
  assign memory_write_data_bits  = q.mem_wdata;
  assign memory_initiate_pulse   = q.init;
  assign inner_word_write_enable = q.inner_we;
  assign outer_word_write_enable = q.outer_we;

endmodule : element_memory_output_stage

// ===== hw/element_memory_pkg.sv
// Constants and types for the element memory output stage
package element_memory_pkg;

  // Clock and in-cycle timing, times in ns
  localparam int unsigned CLK_NS           = 5;
  localparam int unsigned RD_INIT_NS       = 30;
  localparam int unsigned WR_INIT_NS       = 70;
  localparam int unsigned WR_INIT_WIDTH_NS = 50;
  localparam int unsigned WDATA_VALID_NS   = 70;
  localparam int unsigned PROT_STROBE_NS   = 40;
  localparam int unsigned WE_START_NS      = 60;
  localparam int unsigned WE_END_NS        = 210;
  localparam int unsigned CYCLE_END_NS     = 250;

  // Cycle counts: start times round up, end times round down
  localparam logic [7:0] RD_INIT_CYC  = 8'((RD_INIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WR_INIT_CYC  = 8'((WR_INIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WR_INIT_LEN  = 8'(WR_INIT_WIDTH_NS / CLK_NS);
  localparam logic [7:0] WDATA_CYC    = 8'((WDATA_VALID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PROT_CYC     = 8'((PROT_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_START_CYC = 8'((WE_START_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WE_END_CYC   = 8'(WE_END_NS / CLK_NS);
  localparam logic [7:0] CYCLE_END    = 8'(CYCLE_END_NS / CLK_NS);

  // Memory word halves
  localparam logic [63:0] INNER_MASK = 64'h0000_00FF_FFFF_FF00;
  localparam logic [63:0] OUTER_MASK = 64'hFFFF_FF00_0000_00FF;

  // Register map, byte addresses
  localparam int unsigned AXI_ADDR_W  = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_MASK    = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_ERRADDR = 8'h0C;

  // Field positions and reset values
  localparam int unsigned CTRL_CHECK_EN_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_PERR_BIT     = 1;
  localparam logic        CHECK_EN_RST      = 1'b1;
  localparam logic [15:0] PROT_MASK_RST     = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    KIND_READ  = 2'b00,
    KIND_WRITE = 2'b01,
    KIND_XFER  = 2'b10
  } cycle_kind_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

endpackage : element_memory_pkg

// ===== sim/element_memory_model.sv
// Behavioural element memory written by the output stage
`timescale 1ns/100ps
module element_memory_model
  import element_memory_pkg::*;
(
  input wire logic        aclk,
  input wire logic [10:0] addr,
  input wire logic [63:0] wdata,
  input wire logic        init,
  input wire logic        inner_en,
  input wire logic        outer_en
);
  logic [63:0] mem [2048];
  logic        init_q = 1'b0;
  logic [63:0] m;
  initial foreach (mem[i]) mem[i] = 64'h0;
  // Store on the initiate rise, enabled halves only
  always @(posedge aclk)
  begin
    m = (inner_en ? INNER_MASK : 64'h0) | (outer_en ? OUTER_MASK : 64'h0);
    if (init && !init_q)
      mem[addr] <= (mem[addr] & ~m) | (wdata & m);
    init_q <= init;
  end
endmodule : element_memory_model

// ===== sim/element_memory_output_stage_properties.sv
// Timing checks on the element memory output stage
`timescale 1ns/100ps
module element_memory_output_stage_properties
  import element_memory_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        start_write,
  input wire logic        start_read,
  input wire logic        start_transfer,
  input wire logic [10:0] element_address_bits,
  input wire logic [63:0] element_write_data,
  input wire logic        cycle_busy,
  input wire logic [10:0] memory_address_outputs,
  input wire logic [63:0] memory_write_data_bits,
  input wire logic        memory_initiate_pulse,
  input wire logic        inner_word_write_enable,
  input wire logic        outer_word_write_enable
);
  logic       go;
  logic       wr_q;
  logic       xf_q;
  logic [7:0] cnt_q;
  assign go = !cycle_busy && (start_write || start_read || start_transfer);
  // Count of edges since the accepted start
  always_ff @(posedge aclk)
  begin
    if (go)
    begin
      cnt_q <= 8'h00;
      wr_q  <= start_write;
      xf_q  <= !start_write && !start_read;
    end
    else if (cycle_busy)
      cnt_q <= cnt_q + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_pulse:
    assert property (go && !start_write && start_read |-> ##1 !memory_initiate_pulse[*6]
      ##1 memory_initiate_pulse ##1 !memory_initiate_pulse) else $error("read pulse");
  a_write_pulse:
    assert property (go && start_write |-> ##1 !memory_initiate_pulse[*8]
      ##1 !memory_initiate_pulse[*6] ##1 memory_initiate_pulse[*5]
      ##1 memory_initiate_pulse[*5] ##1 !memory_initiate_pulse) else $error("write pulse");
  a_inner_rise:
    assert property ($rose(inner_word_write_enable) |-> wr_q && cnt_q == 8'h0C)
    else $error("inner enable rise");
  a_outer_rise:
    assert property ($rose(outer_word_write_enable) |-> wr_q && cnt_q == 8'h0C)
    else $error("outer enable rise");
  a_enable_fall:
    assert property ($fell(inner_word_write_enable) || $fell(outer_word_write_enable)
      |-> cnt_q == 8'h2A) else $error("enable fall");
  a_xfer_quiet:
    assert property (xf_q && cycle_busy |-> !(memory_initiate_pulse
      || inner_word_write_enable || outer_word_write_enable)) else $error("transfer");
  a_addr_load:
    assert property (go && (start_write || start_read)
      |=> memory_address_outputs == $past(element_address_bits)) else $error("address");
  a_data_valid:
    assert property (go && start_write |-> ##14 $stable(memory_write_data_bits)
      ##1 memory_write_data_bits == $past(element_write_data, 15)) else $error("write data");
  a_busy_len:
    assert property ($fell(cycle_busy) |-> cnt_q == 8'h32) else $error("cycle length");
endmodule : element_memory_output_stage_properties

bind element_memory_output_stage element_memory_output_stage_properties props (.*);

// ===== sim/element_memory_output_stage_tb.sv
// Self-checking bench for the element memory output stage
`timescale 1ns/100ps
module element_memory_output_stage_tb
  import element_memory_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cycle_busy, start_write, start_read, start_transfer;
  logic        write_inner_sel, write_outer_sel, memory_initiate_pulse, chk_en;
  logic        inner_word_write_enable, outer_word_write_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, prot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] element_address_bits, memory_address_outputs, adr;
  logic [63:0] element_write_data, memory_write_data_bits;
  logic [63:0] exp_mem [2048];
  int          fail_count = 0;
  int          compares = 0;
  element_memory_output_stage DUT (.*);
  element_memory_model far_end (
    .aclk     (aclk),
    .addr     (memory_address_outputs),
    .wdata    (memory_write_data_bits),
    .init     (memory_initiate_pulse),
    .inner_en (inner_word_write_enable),
    .outer_en (outer_word_write_enable)
  );
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic give_up();
    fail_count++;
    final_report();
  endtask : give_up
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // One register access; w selects write, d is write data or expected read data
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(w ? s_axi_bvalid : s_axi_rvalid) && ++n < 50);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n >= 50)
      give_up();
    chk("register", 64'(w ? {d, s_axi_bresp} : {s_axi_rdata, s_axi_rresp}), 64'({d, er}));
  endtask : axi
  // One memory cycle; k is 0 write, 1 read, 2 transfer
  task automatic mem_cycle(input int k, input logic [10:0] a, input logic [63:0] d,
                           input logic [1:0] sel);
    int n = 0;
    logic [63:0] m;
    @(posedge aclk);
    {start_write, start_read, start_transfer} <= 3'b100 >> k;
    {element_address_bits, element_write_data} <= {a, d};
    {write_inner_sel, write_outer_sel} <= sel;
    @(posedge aclk);
    {start_write, start_read, start_transfer} <= 3'b000;
    {write_inner_sel, write_outer_sel, element_write_data} <= ~{sel, d};
    do
      @(posedge aclk);
    while (cycle_busy && ++n < 60);
    if (n >= 60)
      give_up();
    m = (sel[1] ? INNER_MASK : 64'h0) | (sel[0] ? OUTER_MASK : 64'h0);
    if (k == 0 && !(chk_en && prot[a[3:0]]))
      exp_mem[a] = (exp_mem[a] & ~m) | (d & m);
    if (k < 2)
      chk("address out", 64'(memory_address_outputs), 64'(a));
    if (k == 0)
      chk("write data", memory_write_data_bits, d);
    chk("memory word", far_end.mem[a], exp_mem[a]);
  endtask : mem_cycle
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
     s_axi_arvalid, s_axi_rready, start_write, start_read, start_transfer, aresetn} = '0;
    {element_address_bits, element_write_data, write_inner_sel, write_outer_sel} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h1A3DD25C;
    prot = 32'h0;
    chk_en = 1'b1;
    foreach (exp_mem[i])
      exp_mem[i] = 64'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, OFS_CTRL, 32'h1, RESP_OKAY);
    axi(0, OFS_MASK, 32'h0, RESP_OKAY);
    axi(1, 8'h10, 32'h5, RESP_SLVERR);
    axi(0, 8'h10, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      adr = (i < 4) ? 11'h7F3 : seed[10:0];
      mem_cycle(0, adr, {seed, lfsr(seed)}, (i < 4) ? 2'(3 - i) : seed[13:12]);
    end
    mem_cycle(1, 11'h7F3, 64'h0, 2'h3);
    mem_cycle(2, 11'h155, '1, 2'h3);
    axi(1, OFS_MASK, 32'h20, RESP_OKAY);
    prot = 32'h20;
    mem_cycle(0, 11'h7F5, {2{seed}}, 2'h3);
    axi(0, OFS_STATUS, 32'h2, RESP_OKAY);
    axi(0, OFS_ERRADDR, 32'h7F5, RESP_OKAY);
    axi(1, OFS_STATUS, 32'h2, RESP_OKAY);
    axi(0, OFS_STATUS, 32'h0, RESP_OKAY);
    mem_cycle(2, 11'h7F5, '0, 2'h3);
    axi(0, OFS_STATUS, 32'h0, RESP_OKAY);
    mem_cycle(0, 11'h7F4, ~{2{seed}}, 2'h3);
    axi(1, OFS_CTRL, 32'h0, RESP_OKAY);
    chk_en = 1'b0;
    mem_cycle(0, 11'h7F5, {2{seed}}, 2'h2);
    final_report();
  end
endmodule : element_memory_output_stage_tb
